//--- core/fieldbus_io_pkg.sv
package fieldbus_io_pkg;

  localparam int unsigned NUM_OUTPUTS = 4;
  localparam int unsigned NUM_PORTS   = 2;

  // Register byte addresses on the APB slave.
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_PASSIVE   = 12'h004;
  localparam logic [11:0] ADDR_SRC_SEL   = 12'h008;
  localparam logic [11:0] ADDR_LOCAL_OUT = 12'h00C;
  localparam logic [11:0] ADDR_STATUS    = 12'h010;
  localparam logic [11:0] ADDR_SAVED     = 12'h014;
  localparam logic [11:0] ADDR_CMD_COUNT = 12'h018;

  // Control register fields.
  localparam int unsigned CTRL_TRIG_FB_BIT = 0;
  localparam int unsigned CTRL_TRIG_PASV   = 1;
  localparam int unsigned CTRL_SAVE_BIT    = 2;

  // Status register fields.
  localparam int unsigned STAT_GATE_BIT  = 0;
  localparam int unsigned STAT_TRIG_BIT  = 1;
  localparam int unsigned STAT_LINK_BIT  = 2;
  localparam int unsigned STAT_INIT_BIT  = 3;
  localparam int unsigned STAT_OUT_LSB   = 8;

  // Reset values of the working parameter set.
  localparam logic [NUM_OUTPUTS-1:0] PASSIVE_RESET = 4'h0;
  localparam logic [NUM_OUTPUTS-1:0] SRC_SEL_RESET = 4'h0;
  localparam logic                   TRIG_PASSIVE_RESET = 1'b0;

  // Framing characters and command words.
  localparam logic [7:0] CHAR_STX   = 8'h02;
  localparam logic [7:0] CHAR_ETX   = 8'h03;
  localparam int unsigned CMD_MAX   = 16;
  localparam int unsigned CMD_LEN_W = 5;
  // Gate open and gate close texts in ASCII, first character highest.
  localparam int unsigned OPEN_LEN  = 13;
  localparam int unsigned CLOSE_LEN = 14;
  localparam logic [CMD_MAX*8-1:0] OPEN_TEXT =
    {24'h000000, 104'h734D4E206D544367617465_6F6E};
  localparam logic [CMD_MAX*8-1:0] CLOSE_TEXT =
    {16'h0000, 112'h734D4E206D544367617465_6F6666};

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_s;

  typedef struct packed {
    logic                   link_up;
    logic                   iops_good;
    logic [NUM_OUTPUTS-1:0] out_data;
    logic                   trig_data;
  } fieldbus_s;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_OPEN,
    CMD_CLOSE
  } cmd_e;

endpackage : fieldbus_io_pkg

//--- core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a bundle of pin levels.
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk, // System clock.
  input  wire logic             rst_n,   // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] async_in, // Level from outside the domain.
  output logic      [WIDTH-1:0] sync_out  // Level safe to use.
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

//--- core/cmd_frame_parser.sv
`timescale 1ns/1ps
`default_nettype none

// Collects one framed command string from a single data interface.
module cmd_frame_parser (
  input  wire logic                   sys_clk, // System clock.
  input  wire logic                   rst_n,   // Asynchronous reset.
  input  wire fieldbus_io_pkg::byte_s rx,      // Received byte strobe.
  output var  fieldbus_io_pkg::cmd_e  cmd,     // Decoded command.
  output logic                        cmd_stb  // One-cycle command pulse.
);

  localparam int unsigned W  = fieldbus_io_pkg::CMD_MAX * 8;
  localparam int unsigned LW = fieldbus_io_pkg::CMD_LEN_W;

  logic                                   in_frame;
  logic [W-1:0]                           text;
  logic [LW-1:0]                          len;
  logic                                   over;

  // Bytes between STX and ETX form one frame; a new STX drops any partial
  // frame so that a lost ETX never merges two commands.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= 1'b0;
      text     <= '0;
      len      <= '0;
      over     <= 1'b0;
    end else if (rx.valid) begin
      if (rx.data == fieldbus_io_pkg::CHAR_STX) begin
        in_frame <= 1'b1;
        text     <= '0;
        len      <= '0;
        over     <= 1'b0;
      end else if (rx.data == fieldbus_io_pkg::CHAR_ETX) begin
        in_frame <= 1'b0;
      end else if (in_frame) begin
        if (len == LW'(fieldbus_io_pkg::CMD_MAX)) begin
          over <= 1'b1;
        end else begin
          text <= {text[W-9:0], rx.data};
          len  <= len + 1'b1;
        end
      end
    end
  end

  // The frame is acted on at the ETX itself, with no staging step.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd     <= fieldbus_io_pkg::CMD_NONE;
      cmd_stb <= 1'b0;
    end else begin
      cmd_stb <= 1'b0;
      if (rx.valid && rx.data == fieldbus_io_pkg::CHAR_ETX && in_frame
          && !over) begin
        cmd_stb <= 1'b1;
        if (len == LW'(fieldbus_io_pkg::OPEN_LEN)
            && text == fieldbus_io_pkg::OPEN_TEXT) begin
          cmd <= fieldbus_io_pkg::CMD_OPEN;
        end else if (len == LW'(fieldbus_io_pkg::CLOSE_LEN)
                     && text == fieldbus_io_pkg::CLOSE_TEXT) begin
          cmd <= fieldbus_io_pkg::CMD_CLOSE;
        end else begin
          cmd <= fieldbus_io_pkg::CMD_NONE;
        end
      end
    end
  end

endmodule : cmd_frame_parser

`default_nettype wire

//--- core/fieldbus_io_hold_and_command_trigger.sv
// Functional notes
// - Each digital output can be set to mirror a value from the fieldbus.
// - On loss of the fieldbus link the mirrored outputs hold their value.
// - While the provider status is bad the mirrored outputs hold.
// - At fieldbus power-up every mirrored output starts at its passive level.
// - The trigger input may come from the fieldbus and freezes on loss.
// - At fieldbus power-up the fieldbus trigger takes its passive level.
// - Command strings are accepted on every data interface.
// - A received command takes effect at once, with no confirm step.
// - Command changes touch only the volatile working parameter set.
// - Gate-open and gate-close commands set and clear a gate that is ORed with the selected trigger into the read pulse.
`timescale 1ns/1ps
`default_nettype none

module fieldbus_io_hold_and_command_trigger #(
  parameter int unsigned NOUT   = fieldbus_io_pkg::NUM_OUTPUTS,
  parameter int unsigned NPORTS = fieldbus_io_pkg::NUM_PORTS
) (
  input  wire logic                  sys_clk,    // System clock, 100 MHz.
  input  wire logic                  rst_n,      // Async reset, active low.
  input  wire logic                  fb_link_up, // Fieldbus link level pin.
  input  wire logic                  fb_iops_good, // Provider status good.
  input  wire logic [NOUT-1:0]       fb_out_data,  // Fieldbus output values.
  input  wire logic                  fb_trig_data, // Fieldbus trigger value.
  input  wire logic                  sensor_in,    // Local trigger pin.
  input  wire fieldbus_io_pkg::byte_s rx_byte [NPORTS], // Data interfaces.
  input  wire logic                  psel,       // APB select.
  input  wire logic                  penable,    // APB enable.
  input  wire logic                  pwrite,     // APB direction.
  input  wire logic [11:0]           paddr,      // APB byte address.
  input  wire logic [31:0]           pwdata,     // APB write data.
  input  wire logic [3:0]            pstrb,      // APB byte strobes.
  output logic      [31:0]           prdata,     // APB read data.
  output logic                       pready,     // APB ready.
  output logic                       pslverr,    // APB error.
  output logic      [NOUT-1:0]       dig_out,    // Digital outputs.
  output logic                       read_gate,  // Reading cycle active.
  output logic                       save_stb    // Save request to storage.
);

  // Pin-level inputs cross into the clock domain first.
  localparam int unsigned SW = NOUT + 4;
  logic [SW-1:0]          pins_sync;
  fieldbus_io_pkg::fieldbus_s fb;
  logic                   sensor_s;

  pin_sync #(
    .WIDTH (SW)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({fb_link_up, fb_iops_good, fb_out_data, fb_trig_data,
                sensor_in}),
    .sync_out (pins_sync)
  );

  assign fb       = pins_sync[SW-1:1];
  assign sensor_s = pins_sync[0];

  // Working parameter set, volatile only.
  logic [NOUT-1:0] passive_lvl;
  logic [NOUT-1:0] src_fieldbus;
  logic [NOUT-1:0] local_out;
  logic            trig_from_fb;
  logic            trig_passive;
  logic [NOUT-1:0] saved_passive;
  logic [15:0]     cmd_count;

  // Fieldbus state.
  logic            fb_valid;
  logic            fb_seen_up;
  logic [NOUT-1:0] fb_out_hold;
  logic            fb_trig_hold;
  logic            gate_cmd;

  // APB decode.
  logic wr_acc;
  logic rd_acc;
  logic known;

  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;

  always_comb begin
    case (paddr)
      fieldbus_io_pkg::ADDR_CTRL,
      fieldbus_io_pkg::ADDR_PASSIVE,
      fieldbus_io_pkg::ADDR_SRC_SEL,
      fieldbus_io_pkg::ADDR_LOCAL_OUT,
      fieldbus_io_pkg::ADDR_STATUS,
      fieldbus_io_pkg::ADDR_SAVED,
      fieldbus_io_pkg::ADDR_CMD_COUNT: known = 1'b1;
      default:                         known = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !known;

  // Register writes change the working set only; nothing persists here.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      passive_lvl  <= fieldbus_io_pkg::PASSIVE_RESET;
      src_fieldbus <= fieldbus_io_pkg::SRC_SEL_RESET;
      local_out    <= '0;
      trig_from_fb <= 1'b0;
      trig_passive <= fieldbus_io_pkg::TRIG_PASSIVE_RESET;
    end else if (wr_acc && pstrb[0]) begin
      case (paddr)
        fieldbus_io_pkg::ADDR_CTRL: begin
          trig_from_fb <= pwdata[fieldbus_io_pkg::CTRL_TRIG_FB_BIT];
          trig_passive <= pwdata[fieldbus_io_pkg::CTRL_TRIG_PASV];
        end
        fieldbus_io_pkg::ADDR_PASSIVE:   passive_lvl  <= pwdata[NOUT-1:0];
        fieldbus_io_pkg::ADDR_SRC_SEL:   src_fieldbus <= pwdata[NOUT-1:0];
        fieldbus_io_pkg::ADDR_LOCAL_OUT: local_out    <= pwdata[NOUT-1:0];
        default: ;
      endcase
    end
  end

  // A save copies the passive levels of the working set toward non-volatile storage on request.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      save_stb      <= 1'b0;
      saved_passive <= fieldbus_io_pkg::PASSIVE_RESET;
    end else begin
      save_stb <= 1'b0;
      if (wr_acc && pstrb[0] && paddr == fieldbus_io_pkg::ADDR_CTRL
          && pwdata[fieldbus_io_pkg::CTRL_SAVE_BIT]) begin
        save_stb      <= 1'b1;
        saved_passive <= passive_lvl;
      end
    end
  end

  // Power-up of the fieldbus is the first rising link; until valid data
  // arrive every mirrored value sits at passive.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_seen_up <= 1'b0;
    end else if (fb.link_up) begin
      fb_seen_up <= 1'b1;
    end
  end

  assign fb_valid = fb.link_up && fb.iops_good;

  // Updating stops on link loss or bad status; the held value is kept,
  // which means a trigger edge during the outage is simply missed.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_out_hold  <= fieldbus_io_pkg::PASSIVE_RESET;
      fb_trig_hold <= fieldbus_io_pkg::TRIG_PASSIVE_RESET;
    end else if (!fb_seen_up) begin
      fb_out_hold  <= passive_lvl;
      fb_trig_hold <= trig_passive;
    end else if (fb_valid) begin
      fb_out_hold  <= fb.out_data;
      fb_trig_hold <= fb.trig_data;
    end
  end

  // Each output chooses the fieldbus copy or the local value.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dig_out <= fieldbus_io_pkg::PASSIVE_RESET;
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        dig_out[i] <= src_fieldbus[i] ? fb_out_hold[i]
                                      : local_out[i];
      end
    end
  end

  // One parser per data interface, so commands are taken on all of them.
  fieldbus_io_pkg::cmd_e cmd     [NPORTS];
  logic [NPORTS-1:0]     cmd_stb;
  logic                  any_open;
  logic                  any_close;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    cmd_frame_parser u_parser (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .rx      (rx_byte[p]),
      .cmd     (cmd[p]),
      .cmd_stb (cmd_stb[p])
    );
  end

  always_comb begin
    any_open  = 1'b0;
    any_close = 1'b0;
    for (int p = 0; p < NPORTS; p++) begin
      if (cmd_stb[p] && cmd[p] == fieldbus_io_pkg::CMD_OPEN) begin
        any_open = 1'b1;
      end
      if (cmd_stb[p] && cmd[p] == fieldbus_io_pkg::CMD_CLOSE) begin
        any_close = 1'b1;
      end
    end
  end

  // Close wins if both arrive together, so a gate is never left stuck open.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cmd <= 1'b0;
    end else if (any_close) begin
      gate_cmd <= 1'b0;
    end else if (any_open) begin
      gate_cmd <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_gate <= 1'b0;
    end else begin
      read_gate <= gate_cmd || (trig_from_fb ? fb_trig_hold : sensor_s);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_count <= '0;
    end else if (|cmd_stb) begin
      cmd_count <= cmd_count + 16'h0001;
    end
  end

  // APB read data, registered in the setup cycle, ready for the access cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else begin
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          fieldbus_io_pkg::ADDR_CTRL: begin
            prdata[fieldbus_io_pkg::CTRL_TRIG_FB_BIT] <= trig_from_fb;
            prdata[fieldbus_io_pkg::CTRL_TRIG_PASV]   <= trig_passive;
          end
          fieldbus_io_pkg::ADDR_PASSIVE:   prdata[NOUT-1:0] <= passive_lvl;
          fieldbus_io_pkg::ADDR_SRC_SEL:   prdata[NOUT-1:0] <= src_fieldbus;
          fieldbus_io_pkg::ADDR_LOCAL_OUT: prdata[NOUT-1:0] <= local_out;
          fieldbus_io_pkg::ADDR_STATUS: begin
            prdata[fieldbus_io_pkg::STAT_GATE_BIT] <= gate_cmd;
            prdata[fieldbus_io_pkg::STAT_TRIG_BIT] <= read_gate;
            prdata[fieldbus_io_pkg::STAT_LINK_BIT] <= fb_valid;
            prdata[fieldbus_io_pkg::STAT_INIT_BIT] <= fb_seen_up;
            prdata[fieldbus_io_pkg::STAT_OUT_LSB +: NOUT] <= dig_out;
          end
          fieldbus_io_pkg::ADDR_SAVED:     prdata[NOUT-1:0] <= saved_passive;
          fieldbus_io_pkg::ADDR_CMD_COUNT: prdata[15:0]     <= cmd_count;
          default: ;
        endcase
      end
    end
  end

  logic unused_ok;
  assign unused_ok = ^{rd_acc, pstrb[3:1], pwdata[31:NOUT]};

endmodule : fieldbus_io_hold_and_command_trigger

`default_nettype wire

//--- tb/fieldbus_io_sva.sv
`timescale 1ns/1ps
`default_nettype none

module fieldbus_io_sva #(
  parameter int unsigned NOUT   = 4,
  parameter int unsigned NPORTS = 2
) (
  input wire logic                   sys_clk,      // Clock.
  input wire logic                   rst_n,        // Reset, active low.
  input wire logic                   fb_link_up,   // Link level.
  input wire logic                   fb_iops_good, // Provider status.
  input wire logic                   fb_trig_data, // Fieldbus trigger.
  input wire logic                   sensor_in,    // Local trigger.
  input wire fieldbus_io_pkg::byte_s rx_byte [NPORTS], // Data ports.
  input wire logic                   psel,         // APB select.
  input wire logic                   penable,      // APB enable.
  input wire logic                   pwrite,       // APB direction.
  input wire logic                   pready,       // APB ready.
  input wire logic [NOUT-1:0]        dig_out,      // Outputs.
  input wire logic                   read_gate,    // Read cycle.
  input wire logic                   save_stb      // Save pulse.
);
  logic       any_rx;
  logic       any_wr;
  logic       sens_q;
  logic       trig_q;
  logic [3:0] quiet;
  logic [3:0] age;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  always_comb begin
    any_rx = 1'b0;
    for (int i = 0; i < NPORTS; i++) any_rx |= rx_byte[i].valid;
  end

  // Quiet counts cycles with a stalled fieldbus and no other stimulus.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      any_wr <= 1'b0;
      sens_q <= 1'b0;
      trig_q <= 1'b0;
      quiet  <= 4'h0;
      age    <= 4'h0;
    end else begin
      any_wr <= any_wr | (psel & pwrite);
      sens_q <= sensor_in;
      trig_q <= fb_trig_data;
      if ((fb_link_up & fb_iops_good) | psel | any_rx | (sensor_in != sens_q))
        quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
      if (psel | any_rx | (sensor_in != sens_q) | (fb_trig_data != trig_q))
        age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
    end
  end

  out_hold_a: assert property (
    quiet > 4'h5 && !fb_link_up |-> $stable(dig_out))
    else $error("outputs moved while link down");
  iops_hold_a: assert property (
    quiet > 4'h5 && fb_link_up |-> $stable(dig_out))
    else $error("outputs moved while provider status bad");
  trig_hold_a: assert property (
    quiet > 4'h5 |-> $stable(read_gate))
    else $error("trigger moved while fieldbus stalled");
  passive_start_a: assert property (!any_wr |-> dig_out == '0)
    else $error("outputs left passive level without setup");
  gate_cause_a: assert property (
    $changed(read_gate) |-> age < 4'h7)
    else $error("read gate changed without a cause");
  save_pulse_a: assert property (save_stb |=> !save_stb)
    else $error("save pulse longer than one cycle");
  save_cause_a: assert property (save_stb |->
    $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("save pulse without a register write");
  ready_zero_a: assert property (psel && penable |-> pready)
    else $error("access was stalled");

  cover property (save_stb);
  cover property ($rose(read_gate));
  cover property (quiet > 4'h5 && fb_link_up);
endmodule : fieldbus_io_sva

bind fieldbus_io_hold_and_command_trigger fieldbus_io_sva #(
  .NOUT(NOUT), .NPORTS(NPORTS)) i_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .fb_link_up(fb_link_up),
  .fb_iops_good(fb_iops_good), .fb_trig_data(fb_trig_data),
  .sensor_in(sensor_in), .rx_byte(rx_byte), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready),
  .dig_out(dig_out), .read_gate(read_gate), .save_stb(save_stb));

`default_nettype wire

//--- tb/fieldbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fieldbus_host_model #(
  parameter int unsigned NOUT   = 4,
  parameter int unsigned NPORTS = 2
) (
  input  wire logic                  sys_clk,      // Clock.
  output var logic                   fb_link_up,   // Link level.
  output var logic                   fb_iops_good, // Provider status.
  output var logic [NOUT-1:0]        fb_out_data,  // Output values.
  output var logic                   fb_trig_data, // Trigger value.
  output var fieldbus_io_pkg::byte_s rx_byte [NPORTS] // Data ports.
);
  localparam int unsigned TW = fieldbus_io_pkg::CMD_MAX * 8;
  logic [NOUT-1:0] value;
  logic            trig;
  logic            link;
  logic            good;
  logic [7:0]      c;
  logic [TW-1:0]   text;
  int              len;

  initial begin
    fb_link_up   = 1'b0;
    fb_iops_good = 1'b0;
    fb_out_data  = '0;
    fb_trig_data = 1'b0;
    value        = '0;
    trig         = 1'b0;
    link         = 1'b0;
    good         = 1'b0;
    foreach (rx_byte[i]) rx_byte[i] = '0;
  end

  // Status and data leave together, as one controller frame carries both;
  // a stalled controller sends nothing valid, so the lines churn.
  always @(posedge sys_clk) begin
    fb_link_up   <= link;
    fb_iops_good <= good;
    if (link && good) begin
      fb_out_data  <= value;
      fb_trig_data <= trig;
    end else begin
      fb_out_data  <= ~fb_out_data;
      fb_trig_data <= ~fb_trig_data;
    end
  end

  task set_bus(input logic l, input logic g, input logic [NOUT-1:0] v,
               input logic t);
    @(posedge sys_clk);
    link  <= l;
    good  <= g;
    value <= v;
    trig  <= t;
  endtask : set_bus

  // Sends the gate open or close text; terminal-style hosts send it bare,
  // without the framing characters.
  task send_gate(input int p, input bit is_open, input bit stx,
                 input bit etx);
    text = is_open ? fieldbus_io_pkg::OPEN_TEXT : fieldbus_io_pkg::CLOSE_TEXT;
    len  = is_open ? fieldbus_io_pkg::OPEN_LEN : fieldbus_io_pkg::CLOSE_LEN;
    c    = fieldbus_io_pkg::CHAR_STX;
    if (stx) begin
      @(posedge sys_clk);
      rx_byte[p] <= '{1'b1, c};
    end
    for (int i = len - 1; i >= 0; i--) begin
      c = text[i*8 +: 8];
      @(posedge sys_clk);
      rx_byte[p] <= '{1'b1, c};
    end
    if (etx) begin
      c = fieldbus_io_pkg::CHAR_ETX;
      @(posedge sys_clk);
      rx_byte[p] <= '{1'b1, c};
    end
    @(posedge sys_clk);
    rx_byte[p] <= '{1'b0, ~c};
  endtask : send_gate
endmodule : fieldbus_host_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int unsigned NOUT   = 4;
  localparam int unsigned NPORTS = 2;
  logic                   sys_clk = 1'b0;
  logic                   rst_n   = 1'b0;
  logic                   sensor_in = 1'b0;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [11:0]            paddr   = 12'h000;
  logic [31:0]            pwdata  = 32'h0;
  logic [3:0]             pstrb   = 4'h0;
  logic                   fb_link_up, fb_iops_good, fb_trig_data;
  logic [NOUT-1:0]        fb_out_data, dig_out;
  fieldbus_io_pkg::byte_s rx_byte [NPORTS];
  logic [31:0]            prdata, q;
  logic                   pready, pslverr, read_gate, save_stb, e;
  int                     miscompares = 0;
  int                     comparisons = 0;
  int                     saves = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (save_stb === 1'b1) saves++;

  fieldbus_host_model #(.NOUT(NOUT), .NPORTS(NPORTS)) i_host (
    .sys_clk(sys_clk), .fb_link_up(fb_link_up), .fb_iops_good(fb_iops_good),
    .fb_out_data(fb_out_data), .fb_trig_data(fb_trig_data),
    .rx_byte(rx_byte));
  fieldbus_io_hold_and_command_trigger #(.NOUT(NOUT), .NPORTS(NPORTS)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .fb_link_up(fb_link_up),
    .fb_iops_good(fb_iops_good), .fb_out_data(fb_out_data),
    .fb_trig_data(fb_trig_data), .sensor_in(sensor_in), .rx_byte(rx_byte),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dig_out(dig_out), .read_gate(read_gate),
    .save_stb(save_stb));

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end else begin
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic r);
    xfer(a, 1'b0, 32'h0, 4'h0);
    check(q, x);
    check({31'h0, e}, {31'h0, r});
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_n

  task automatic t_reset_regs();
    logic [11:0] regs [6];
    regs = '{fieldbus_io_pkg::ADDR_CTRL, fieldbus_io_pkg::ADDR_PASSIVE,
             fieldbus_io_pkg::ADDR_SRC_SEL, fieldbus_io_pkg::ADDR_LOCAL_OUT,
             fieldbus_io_pkg::ADDR_SAVED, fieldbus_io_pkg::ADDR_CMD_COUNT};
    foreach (regs[i]) rd(regs[i], 32'h0, 1'b0);
    xfer(fieldbus_io_pkg::ADDR_LOCAL_OUT, 1'b1, 32'hF, 4'h0);
    rd(fieldbus_io_pkg::ADDR_LOCAL_OUT, 32'h0, 1'b0);
    xfer(12'h01C, 1'b1, 32'hFFFFFFFF, 4'hF);
    rd(12'h01C, 32'h0, 1'b1);
    check({28'h0, dig_out}, 32'h0);
  endtask : t_reset_regs

  task automatic t_commands();
    i_host.send_gate(0, 1'b1, 1'b1, 1'b1);
    wait_n(2);
    check({31'h0, read_gate}, 32'h0);
    wait_n(1);
    check({31'h0, read_gate}, 32'h1);
    i_host.send_gate(1, 1'b0, 1'b1, 1'b1);
    wait_n(4);
    check({31'h0, read_gate}, 32'h0);
    i_host.send_gate(0, 1'b0, 1'b1, 1'b0);
    i_host.send_gate(0, 1'b1, 1'b1, 1'b1);
    wait_n(4);
    check({31'h0, read_gate}, 32'h1);
    i_host.send_gate(1, 1'b0, 1'b0, 1'b0);
    wait_n(4);
    check({31'h0, read_gate}, 32'h1);
    i_host.send_gate(0, 1'b0, 1'b1, 1'b1);
    wait_n(4);
    check({31'h0, read_gate}, 32'h0);
    rd(fieldbus_io_pkg::ADDR_CMD_COUNT, 32'h4, 1'b0);
    sensor_in <= 1'b1;
    wait_n(5);
    check({31'h0, read_gate}, 32'h1);
    sensor_in <= 1'b0;
    wait_n(5);
    check({31'h0, read_gate}, 32'h0);
  endtask : t_commands

  task automatic t_powerup();
    wr(fieldbus_io_pkg::ADDR_PASSIVE, 32'hA);
    wr(fieldbus_io_pkg::ADDR_SRC_SEL, 32'hC);
    wr(fieldbus_io_pkg::ADDR_LOCAL_OUT, 32'h3);
    wr(fieldbus_io_pkg::ADDR_CTRL, 32'h3);
    wait_n(4);
    check({28'h0, dig_out}, 32'hB);
    check({31'h0, read_gate}, 32'h1);
    i_host.set_bus(1'b1, 1'b1, 4'h5, 1'b0);
    wait_n(8);
    check({28'h0, dig_out}, 32'h7);
    check({31'h0, read_gate}, 32'h0);
    rd(fieldbus_io_pkg::ADDR_STATUS, 32'h70C, 1'b0);
  endtask : t_powerup

  task automatic t_hold();
    i_host.set_bus(1'b0, 1'b1, 4'hF, 1'b1);
    wait_n(8);
    check({28'h0, dig_out}, 32'h7);
    check({31'h0, read_gate}, 32'h0);
    i_host.set_bus(1'b1, 1'b0, 4'hF, 1'b1);
    wait_n(8);
    check({28'h0, dig_out}, 32'h7);
    check({31'h0, read_gate}, 32'h0);
    i_host.set_bus(1'b1, 1'b1, 4'hF, 1'b1);
    wait_n(8);
    check({28'h0, dig_out}, 32'hF);
    check({31'h0, read_gate}, 32'h1);
  endtask : t_hold

  task automatic t_save();
    wr(fieldbus_io_pkg::ADDR_PASSIVE, 32'h6);
    rd(fieldbus_io_pkg::ADDR_SAVED, 32'h0, 1'b0);
    wr(fieldbus_io_pkg::ADDR_CTRL, 32'h7);
    wait_n(2);
    check(saves, 32'h1);
    rd(fieldbus_io_pkg::ADDR_CTRL, 32'h3, 1'b0);
    rd(fieldbus_io_pkg::ADDR_SAVED, 32'h6, 1'b0);
  endtask : t_save

  initial begin
    wait_n(8);
    rst_n <= 1'b1;
    wait_n(3);
    t_reset_regs();
    t_commands();
    t_powerup();
    t_hold();
    t_save();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
